// File: rtl/pfc_consts.vh
// timing and command constants for the page flash host controller
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH
`define PFC_CLK_NS        100
`define PFC_LOAD_WIN_US   200
`define PFC_LOAD_TO_US    300
`define PFC_ID_WAIT_US    10
`define PFC_ERASE_MS      50
`define PFC_PROG_MS       10
// cycle counts: longest times round down, least times round up
`define PFC_LOAD_WIN_CYC  ((`PFC_LOAD_WIN_US*1000)/`PFC_CLK_NS)
`define PFC_LOAD_TO_CYC   ((`PFC_LOAD_TO_US*1000+`PFC_CLK_NS-1)/`PFC_CLK_NS)
`define PFC_ID_WAIT_CYC   ((`PFC_ID_WAIT_US*1000+`PFC_CLK_NS-1)/`PFC_CLK_NS)
`define PFC_ERASE_CYC     ((`PFC_ERASE_MS*1000000+`PFC_CLK_NS-1)/`PFC_CLK_NS)
`define PFC_PROG_CYC      ((`PFC_PROG_MS*1000000+`PFC_CLK_NS-1)/`PFC_CLK_NS)
`define PFC_ADDR_5555     17'h05555
`define PFC_ADDR_2AAA     17'h02AAA
`define PFC_ID_MAKER_ADR  17'h00000
`define PFC_ID_PART_ADR   17'h00001
`define PFC_CMD_AA        8'hAA
`define PFC_CMD_55        8'h55
`define PFC_CMD_PROT      8'hA0
`define PFC_CMD_EXT       8'h80
`define PFC_CMD_UNPROT    8'h20
`define PFC_CMD_ERASE     8'h10
`define PFC_CMD_ID_IN     8'h60
`define PFC_CMD_ID_OUT    8'hF0
`define PFC_PAGE_LSB      7
`define PFC_PAGE_BYTES    128
`define PFC_ERASED        8'hFF
`define PFC_POLL_BIT      7
`define PFC_TOGGLE_BIT    6
`define PFC_OP_READ       3'h0
`define PFC_OP_PAGE       3'h1
`define PFC_OP_PROT_ON    3'h2
`define PFC_OP_PROT_OFF   3'h3
`define PFC_OP_ERASE      3'h4
`define PFC_OP_ID_IN      3'h5
`define PFC_OP_ID_OUT     3'h6
`endif

// File: rtl/pfc_page_mem.v
// page staging memory: 128 bytes with a registered read port; the loaded flags live in the host
`timescale 1ns/10ps
`include "pfc_consts.vh"
module pfc_page_mem (
  input  wire       clock,
  input  wire       wr_en,
  input  wire [6:0] wr_idx,
  input  wire [7:0] wr_data,
  input  wire [6:0] rd_idx,
  output reg  [7:0] rd_data_ff
);
  reg [7:0] mem [0:`PFC_PAGE_BYTES-1];

  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data_ff <= mem[rd_idx];
  end
endmodule // pfc_page_mem

// File: rtl/pfc_host.v
// host controller that drives the page flash through its bus pins
`timescale 1ns/10ps
`include "pfc_consts.vh"
// Function
// - read only with chip select and output gate both low
// - unloaded page bytes become FFh after programming
// - write: select and strobe low, output gate held high
// - next byte loaded within 200 us keeps page load open
// - address bits 7..16 pick page, same for whole page; 0..6 byte
// - protected loads start with AA/5555, 55/2AAA, A0/5555
// - disable: AA,55,80,AA,55,20 to 5555/2AAA/5555 pattern
// - six-write chip erase, self-timed, done within 50 ms
// - three-write sequence leaves id mode
// - id entry six writes with 60, exit three with F0; wait 10 us
module pfc_host (
  input  wire        clock,
  input  wire        resetn,
  input  wire        req_valid,
  input  wire [2:0]  req_op,
  input  wire [16:0] req_addr,
  input  wire [7:0]  req_data,
  input  wire        req_protect,
  output reg         req_ready_ff,
  output reg         rsp_valid_ff,
  output reg  [7:0]  rsp_data_ff,
  output reg         done_ff,
  output reg         chip_select_n_ff,
  output reg         output_gate_n_ff,
  output reg         write_strobe_n_ff,
  output reg  [16:0] address_lines_ff,
  output reg  [7:0]  data_lines_out_ff,
  output reg         data_lines_oe_n_ff,
  input  wire [7:0]  data_lines_in
);
  // ----------------------------------------------------------------
  // states and phases
  // ----------------------------------------------------------------
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_CMD  = 8'h02;
  localparam [7:0] S_LOAD = 8'h04;
  localparam [7:0] S_FILL = 8'h08;
  localparam [7:0] S_WAIT = 8'h10;
  localparam [7:0] S_POLL = 8'h20;
  localparam [7:0] S_READ = 8'h40;
  localparam [7:0] S_PAUS = 8'h80;
  // one pin cycle lasts four clocks: setup, strobe low, strobe low, rise
  localparam [1:0] PH_LAST = 2'h3;
  localparam [20:0] LOAD_WIN = `PFC_LOAD_WIN_CYC;
  localparam [20:0] LOAD_TO  = `PFC_LOAD_TO_CYC;
  localparam [20:0] ID_WAIT  = `PFC_ID_WAIT_CYC;
  localparam [20:0] ERASE_T  = `PFC_ERASE_CYC;

  // command write k of a sequence: address and data
  function [24:0] cmd_word;
    input [2:0] op;
    input [2:0] k;
    reg   [7:0] last;
    begin
      last = `PFC_CMD_PROT;
      if (op == `PFC_OP_PROT_OFF) last = `PFC_CMD_UNPROT;
      else if (op == `PFC_OP_ERASE) last = `PFC_CMD_ERASE;
      else if (op == `PFC_OP_ID_IN) last = `PFC_CMD_ID_IN;
      else if (op == `PFC_OP_ID_OUT) last = `PFC_CMD_ID_OUT;
      cmd_word = {`PFC_ADDR_5555, `PFC_CMD_AA};
      if (k == 3'h1 || k == 3'h4) cmd_word = {`PFC_ADDR_2AAA, `PFC_CMD_55};
      else if (k == 3'h2 && (op == `PFC_OP_PROT_ON ||
               op == `PFC_OP_PAGE || op == `PFC_OP_ID_OUT))
        cmd_word = {`PFC_ADDR_5555, last};
      else if (k == 3'h2) cmd_word = {`PFC_ADDR_5555, `PFC_CMD_EXT};
      else if (k == 3'h5) cmd_word = {`PFC_ADDR_5555, last};
    end
  endfunction

  function [2:0] cmd_len;
    input [2:0] op;
    begin
      if (op == `PFC_OP_PROT_OFF || op == `PFC_OP_ERASE ||
          op == `PFC_OP_ID_IN) cmd_len = 3'h6;
      else cmd_len = 3'h3;
    end
  endfunction

  // ----------------------------------------------------------------
  // reset release and pin input sync
  // ----------------------------------------------------------------
  reg        rst_a_ff, rst_b_ff;
  reg [7:0]  dq_s1_ff, dq_s2_ff, dq_s3_ff;
  wire       rst_n = rst_b_ff;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
      dq_s3_ff <= 8'h00;
    end else begin
      dq_s1_ff <= data_lines_in;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
    end
  end
  wire dq_stable = (dq_s2_ff == dq_s3_ff);

  // ----------------------------------------------------------------
  // page staging
  // ----------------------------------------------------------------
  reg  [7:0]   state_ff;
  reg  [2:0]   op_ff;
  reg  [2:0]   step_ff;
  reg  [1:0]   ph_ff;
  reg  [20:0]  tmr_ff;
  reg  [9:0]   page_ff;
  reg  [6:0]   idx_ff;
  reg  [127:0] loaded_ff;
  reg  [7:0]   last_data_ff;
  reg  [6:0]   last_idx_ff;
  reg          have_page_ff;
  reg          prev_t_ff;
  reg          poll_rd_ff;
  wire [7:0]   mem_q;
  // look one byte ahead so the registered read data is ready at phase 0
  wire [6:0]   rd_idx = (state_ff == S_IDLE) ? 7'h00 :
                        (state_ff == S_LOAD && ph_ff == PH_LAST) ?
                        idx_ff + 7'h01 : idx_ff;
  wire         stage_wr = state_ff == S_IDLE && req_valid &&
                          req_op == `PFC_OP_PAGE &&
                          (!have_page_ff ||
                           req_addr[16:7] == page_ff);

  pfc_page_mem u_mem (
    .clock      (clock),
    .wr_en      (stage_wr),
    .wr_idx     (req_addr[6:0]),
    .wr_data    (req_data),
    .rd_idx     (rd_idx),
    .rd_data_ff (mem_q)
  );

  // ----------------------------------------------------------------
  // pin sequencer
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff           <= S_IDLE;
      op_ff              <= `PFC_OP_READ;
      step_ff            <= 3'h0;
      ph_ff              <= 2'h0;
      tmr_ff             <= 21'h000000;
      page_ff            <= 10'h000;
      idx_ff             <= 7'h00;
      loaded_ff          <= {128{1'b0}};
      last_data_ff       <= 8'h00;
      last_idx_ff        <= 7'h00;
      have_page_ff       <= 1'b0;
      prev_t_ff          <= 1'b0;
      poll_rd_ff         <= 1'b0;
      req_ready_ff       <= 1'b0;
      rsp_valid_ff       <= 1'b0;
      rsp_data_ff        <= 8'h00;
      done_ff            <= 1'b0;
      chip_select_n_ff   <= 1'b1;
      output_gate_n_ff   <= 1'b1;
      write_strobe_n_ff  <= 1'b1;
      address_lines_ff   <= 17'h00000;
      data_lines_out_ff  <= 8'h00;
      data_lines_oe_n_ff <= 1'b1;
    end else begin
      rsp_valid_ff <= 1'b0;
      done_ff      <= 1'b0;
      req_ready_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          req_ready_ff <= 1'b1;
          if (req_valid && req_ready_ff) begin
            req_ready_ff <= 1'b0;
            op_ff        <= req_op;
            step_ff      <= 3'h0;
            ph_ff        <= 2'h0;
            if (req_op == `PFC_OP_READ) begin
              // gate drops at once: the data needs three sync clocks
              address_lines_ff   <= req_addr;
              chip_select_n_ff   <= 1'b0;
              output_gate_n_ff   <= 1'b0;
              data_lines_oe_n_ff <= 1'b1;
              state_ff           <= S_READ;
            end else if (req_op == `PFC_OP_PAGE) begin
              // staged only; one whole page goes out in one burst
              if (stage_wr) begin
                page_ff                   <= req_addr[16:7];
                loaded_ff[req_addr[6:0]]  <= 1'b1;
                have_page_ff              <= 1'b1;
                last_idx_ff               <= req_addr[6:0];
                last_data_ff              <= req_data;
              end
              rsp_valid_ff <= 1'b1;
              rsp_data_ff  <= stage_wr ? 8'h00 : 8'h01;
            end else if (req_op == `PFC_OP_PROT_ON && have_page_ff) begin
              state_ff <= req_protect ? S_CMD : S_LOAD;
              idx_ff   <= 7'h00;
            end else if (req_op != `PFC_OP_PROT_ON) begin
              state_ff <= S_CMD;
            end else begin
              rsp_valid_ff <= 1'b1;
              rsp_data_ff  <= 8'h01;
            end
          end
        end
        S_CMD: begin
          // command writes: unlock prefix of protected page loads, and the disable, erase and id sequences
          ph_ff <= ph_ff + 2'h1;
          chip_select_n_ff   <= 1'b0;
          output_gate_n_ff   <= 1'b1;
          data_lines_oe_n_ff <= 1'b0;
          {address_lines_ff, data_lines_out_ff}
            <= cmd_word(op_ff, step_ff);
          // two clocks low = 200 ns, far beyond the noise filter
          write_strobe_n_ff <= (ph_ff == 2'h1 || ph_ff == 2'h2) ?
                               1'b0 : 1'b1;
          if (ph_ff == PH_LAST) begin
            chip_select_n_ff <= 1'b1;
            step_ff          <= step_ff + 3'h1;
            if (step_ff + 3'h1 == cmd_len(op_ff)) begin
              step_ff <= 3'h0;
              tmr_ff  <= 21'h000000;
              if (op_ff == `PFC_OP_PROT_ON) begin
                state_ff <= S_LOAD;
                idx_ff   <= 7'h00;
              end else if (op_ff == `PFC_OP_ERASE) begin
                state_ff <= S_WAIT;
              end else begin
                state_ff <= S_PAUS;
              end
            end
          end
        end
        S_LOAD: begin
          // full page, unloaded bytes filled with erased value
          ph_ff <= ph_ff + 2'h1;
          chip_select_n_ff   <= 1'b0;
          output_gate_n_ff   <= 1'b1;
          data_lines_oe_n_ff <= 1'b0;
          address_lines_ff   <= {page_ff, idx_ff};
          data_lines_out_ff  <= loaded_ff[idx_ff] ? mem_q :
                                `PFC_ERASED;
          write_strobe_n_ff  <= (ph_ff == 2'h1 || ph_ff == 2'h2) ?
                                1'b0 : 1'b1;
          if (ph_ff == PH_LAST) begin
            chip_select_n_ff <= 1'b1;
            idx_ff           <= idx_ff + 7'h01;
            if (idx_ff == 7'h7F) begin
              state_ff <= S_FILL;
              tmr_ff   <= 21'h000000;
            end
          end
        end
        S_FILL: begin
          // let the load window expire so the device starts programming
          data_lines_oe_n_ff <= 1'b1;
          tmr_ff             <= tmr_ff + 21'h000001;
          if (tmr_ff == LOAD_TO) begin
            state_ff   <= S_POLL;
            ph_ff      <= 2'h0;
            idx_ff     <= last_idx_ff;
            poll_rd_ff <= 1'b0;
          end
        end
        S_POLL: begin
          // repeated reads of the last staged byte until bit 7 matches the staged data and bit 6 holds still over two reads
          ph_ff            <= ph_ff + 2'h1;
          address_lines_ff <= {page_ff, last_idx_ff};
          chip_select_n_ff <= 1'b0;
          output_gate_n_ff <= (ph_ff == PH_LAST) ? 1'b1 : 1'b0;
          if (ph_ff == PH_LAST) begin
            step_ff <= 3'h1;
          end
          // judge a read at the next gate fall, once it has passed the sync
          if (ph_ff == 2'h0 && step_ff != 3'h0 && dq_stable) begin
            poll_rd_ff <= 1'b1;
            prev_t_ff  <= dq_s3_ff[`PFC_TOGGLE_BIT];
            if (dq_s3_ff[`PFC_POLL_BIT] == last_data_ff[`PFC_POLL_BIT] &&
                (!poll_rd_ff ||
                 prev_t_ff == dq_s3_ff[`PFC_TOGGLE_BIT])) begin
              if (poll_rd_ff) begin
                state_ff         <= S_IDLE;
                step_ff          <= 3'h0;
                chip_select_n_ff <= 1'b1;
                output_gate_n_ff <= 1'b1;
                loaded_ff        <= {128{1'b0}};
                have_page_ff     <= 1'b0;
                done_ff          <= 1'b1;
              end
            end
          end
        end
        S_WAIT: begin
          data_lines_oe_n_ff <= 1'b1;
          tmr_ff             <= tmr_ff + 21'h000001;
          if (tmr_ff == ERASE_T) begin
            state_ff <= S_IDLE;
            done_ff  <= 1'b1;
          end
        end
        S_PAUS: begin
          data_lines_oe_n_ff <= 1'b1;
          tmr_ff             <= tmr_ff + 21'h000001;
          if (tmr_ff == ID_WAIT) begin
            state_ff <= S_IDLE;
            done_ff  <= 1'b1;
          end
        end
        S_READ: begin
          // id reads at 0000H/0001H use this same path
          ph_ff              <= ph_ff + 2'h1;
          data_lines_oe_n_ff <= 1'b1;
          chip_select_n_ff   <= 1'b0;
          output_gate_n_ff   <= 1'b0;
          if (ph_ff == PH_LAST) begin
            chip_select_n_ff <= 1'b1;
            output_gate_n_ff <= 1'b1;
            rsp_valid_ff     <= 1'b1;
            rsp_data_ff      <= dq_s3_ff;
            state_ff         <= S_IDLE;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule // pfc_host

// File: verif/pfc_host_sva.sv
// assertions on the host pins and request timing
`timescale 1ns/10ps
module pfc_host_sva (
  input wire        clock,
  input wire        resetn,
  input wire        req_valid,
  input wire [2:0]  req_op,
  input wire        req_ready_ff,
  input wire        rsp_valid_ff,
  input wire        chip_select_n_ff,
  input wire        output_gate_n_ff,
  input wire        write_strobe_n_ff,
  input wire [16:0] address_lines_ff,
  input wire [7:0]  data_lines_out_ff,
  input wire        data_lines_oe_n_ff
);
  // ---------------------------
  // idle cycles since last strobe
  // ---------------------------
  reg  [11:0] gap_ff;
  wire        tk = req_valid && req_ready_ff;
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      gap_ff <= 12'h000;
    else if (!write_strobe_n_ff)
      gap_ff <= 12'h000;
    else if (gap_ff != 12'hFFF)
      gap_ff <= gap_ff + 12'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_wr;
    !write_strobe_n_ff |-> !chip_select_n_ff && output_gate_n_ff;
  endproperty
  a_wr: assert property (p_wr)
    else $error("strobe low without select or with gate low");
  property p_rd;
    !output_gate_n_ff |-> !chip_select_n_ff && data_lines_oe_n_ff;
  endproperty
  a_rd: assert property (p_rd)
    else $error("gate low without select or while driving");
  property p_clash;
    !data_lines_oe_n_ff |-> output_gate_n_ff;
  endproperty
  a_clash: assert property (p_clash)
    else $error("host drives while device may drive");
  property p_pulse;
    $fell(write_strobe_n_ff) |=> !write_strobe_n_ff;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("strobe pulse too short");
  property p_hold;
    !write_strobe_n_ff |-> $stable(address_lines_ff)
      && $stable(data_lines_out_ff) && !data_lines_oe_n_ff;
  endproperty
  a_hold: assert property (p_hold)
    else $error("address or data moved under strobe");
  // a gap between 200 us and 300 us leaves the load state undefined
  property p_gap;
    $fell(write_strobe_n_ff) |-> gap_ff < 12'h7D0 || gap_ff >= 12'hBB8;
  endproperty
  a_gap: assert property (p_gap)
    else $error("strobe gap in ambiguous window");
  property p_rlat;
    tk && req_op == 3'h0 |-> ##5 rsp_valid_ff;
  endproperty
  a_rlat: assert property (p_rlat)
    else $error("read answer late");
  property p_slat;
    tk && req_op == 3'h1 |=> rsp_valid_ff;
  endproperty
  a_slat: assert property (p_slat)
    else $error("stage answer late");
  property p_take;
    tk |=> !req_ready_ff;
  endproperty
  a_take: assert property (p_take)
    else $error("ready stayed high after take");
endmodule // pfc_host_sva
bind pfc_host pfc_host_sva u_sva (
  .clock(clock), .resetn(resetn), .req_valid(req_valid),
  .req_op(req_op), .req_ready_ff(req_ready_ff),
  .rsp_valid_ff(rsp_valid_ff), .chip_select_n_ff(chip_select_n_ff),
  .output_gate_n_ff(output_gate_n_ff),
  .write_strobe_n_ff(write_strobe_n_ff),
  .address_lines_ff(address_lines_ff),
  .data_lines_out_ff(data_lines_out_ff),
  .data_lines_oe_n_ff(data_lines_oe_n_ff));

// File: verif/pfc_flash_model.sv
// behavioural page flash device on the host pins
`timescale 1ns/10ps
module pfc_flash_model #(
  parameter LOAD_TO_NS = 300000,
  parameter PROG_NS    = 20000,
  parameter MAKER_ID   = 8'h3C, // arbitrary value
  parameter PART_ID    = 8'h5A  // arbitrary value
) (
  input  wire        chip_select_n,
  input  wire        output_gate_n,
  input  wire        write_strobe_n,
  input  wire [16:0] address_lines,
  input  wire [7:0]  host_data,
  input  wire        host_oe_n,
  output wire [7:0]  data_lines
);
  localparam A5 = 17'h05555;
  localparam A2 = 17'h02AAA;
  reg [7:0]   mem [int];
  reg [7:0]   buf_q [0:127];
  reg [127:0] ldm_q;
  reg [9:0]   pg_q;
  reg [16:0]  a_q;
  reg [7:0]   rd_q = 8'h00;
  reg [7:0]   last_q = 8'h00;
  reg [7:0]   ld_q;
  reg [2:0]   step_q = 3'h0;
  reg         prot_q = 1'b1;
  reg         id_q = 1'b0;
  reg         open_q = 1'b0;
  reg         arm_q = 1'b0;
  reg         busy_q = 1'b0;
  reg         tog_q = 1'b0;
  reg         wr_q = 1'b0;
  integer     erase_cnt = 0;
  integer     i;
  time        t_fall;
  time        t_last;
  time        t_end;
  wire        drv = !chip_select_n && !output_gate_n;
  // released lines show the inverse so a stale value never passes
  assign data_lines = !host_oe_n ? host_data : drv ? rd_q : ~last_q;
  always @(negedge drv) last_q = rd_q;
  task chk_to;
    begin
      if (open_q && $time - t_last >= LOAD_TO_NS) begin
        open_q = 1'b0;
        busy_q = 1'b1;
        t_end = $time + PROG_NS;
      end
      if (busy_q && $time >= t_end) begin
        for (i = 0; i < 128; i = i + 1)
          mem[{pg_q, i[6:0]}] = ldm_q[i] ? buf_q[i] : 8'hFF;
        busy_q = 1'b0;
      end
    end
  endtask
  always #1000 chk_to;
  task ld(input [16:0] a, input [7:0] d);
    begin
      if (!open_q) begin
        open_q = 1'b1;
        pg_q = a[16:7];
        ldm_q = 128'h0;
      end
      arm_q = 1'b0;
      if (a[16:7] == pg_q) begin
        buf_q[a[6:0]] = d;
        ldm_q[a[6:0]] = 1'b1;
        ld_q = d;
        t_last = $time;
      end
    end
  endtask
  task do_wr(input [16:0] a, input [7:0] d);
    begin
      if (busy_q)
        i = 0;
      else if (open_q || arm_q)
        ld(a, d);
      else if (step_q == 0 && a == A5 && d == 8'hAA)
        step_q = 3'h1;
      else if (step_q == 1 && a == A2 && d == 8'h55)
        step_q = 3'h2;
      else if (step_q == 2 && a == A5 && d == 8'h80)
        step_q = 3'h3;
      else if (step_q == 3 && a == A5 && d == 8'hAA)
        step_q = 3'h4;
      else if (step_q == 4 && a == A2 && d == 8'h55)
        step_q = 3'h5;
      else begin
        if (step_q == 2 && a == A5 && d == 8'hA0) begin
          prot_q = 1'b1;
          arm_q = 1'b1;
        end
        if (step_q == 2 && a == A5 && d == 8'hF0)
          id_q = 1'b0;
        if (step_q == 5 && a == A5 && d == 8'h20)
          prot_q = 1'b0;
        if (step_q == 5 && a == A5 && d == 8'h10) begin
          mem.delete();
          erase_cnt = erase_cnt + 1;
        end
        if (step_q == 5 && a == A5 && d == 8'h60)
          id_q = 1'b1;
        if (step_q == 0 && !prot_q)
          ld(a, d);
        step_q = 3'h0;
      end
    end
  endtask
  always @(negedge write_strobe_n or negedge chip_select_n)
    if (!write_strobe_n && !chip_select_n && output_gate_n) begin
      wr_q = 1'b1;
      t_fall = $time;
      a_q = address_lines;
    end
  always @(posedge write_strobe_n or posedge chip_select_n)
    if (wr_q) begin
      wr_q = 1'b0;
      if ($time - t_fall >= 15)
        do_wr(a_q, host_data);
    end
  always @(negedge output_gate_n) begin
    chk_to;
    #1;
    if (busy_q) begin
      rd_q = {~ld_q[7], tog_q, ld_q[5:0]};
      tog_q = ~tog_q;
    end else if (id_q && address_lines < 17'h00002)
      rd_q = address_lines[0] ? PART_ID : MAKER_ID;
    else
      rd_q = mem.exists(address_lines) ? mem[address_lines] : 8'hFF;
  end
endmodule // pfc_flash_model

// File: verif/pfc_host_tb.sv
// self-checking bench for the page flash host controller
`timescale 1ns/10ps
module pfc_host_tb;
  reg         clock = 1'b0;
  reg         resetn = 1'b0;
  reg         req_valid = 1'b0;
  reg  [2:0]  req_op = 3'h0;
  reg  [16:0] req_addr = 17'h00000;
  reg  [7:0]  req_data = 8'h00;
  reg         req_protect = 1'b0;
  wire        rdy, rsp_v, done, cs_n, og_n, ws_n, oe_n;
  wire [7:0]  rsp_d, dout, din;
  wire [16:0] adr;
  integer     num_errors = 0;
  integer     checks_done = 0;
  integer     n;
  reg  [7:0]  got;
  always #50 clock = ~clock;
  pfc_host uut (.clock(clock), .resetn(resetn), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .req_protect(req_protect), .req_ready_ff(rdy), .rsp_valid_ff(rsp_v),
    .rsp_data_ff(rsp_d), .done_ff(done), .chip_select_n_ff(cs_n),
    .output_gate_n_ff(og_n), .write_strobe_n_ff(ws_n),
    .address_lines_ff(adr), .data_lines_out_ff(dout),
    .data_lines_oe_n_ff(oe_n), .data_lines_in(din));
  pfc_flash_model #(.MAKER_ID(8'h3C), .PART_ID(8'h5A)) u_dev (
    .chip_select_n(cs_n), .output_gate_n(og_n), .write_strobe_n(ws_n),
    .address_lines(adr), .host_data(dout), .host_oe_n(oe_n),
    .data_lines(din));
  task end_sim;
    begin
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task tmo;
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t wait limit hit", $time);
      end_sim;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // ---------------------------
  // request and answer helpers
  // ---------------------------
  task req(input [2:0] op, input [16:0] a, input [7:0] d, input p);
    begin
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_data <= d;
      req_protect <= p;
      n = 0;
      @(posedge clock);
      while (rdy !== 1'b1) begin
        n = n + 1;
        if (n > 1000)
          tmo;
        @(posedge clock);
      end
      req_valid <= 1'b0;
    end
  endtask
  task wt(input rsp, input integer lim);
    begin
      n = 0;
      @(posedge clock);
      while ((rsp ? rsp_v : done) !== 1'b1) begin
        n = n + 1;
        if (n > lim)
          tmo;
        @(posedge clock);
      end
      got = rsp_d;
    end
  endtask
  task rd(input [16:0] a, input [7:0] e);
    begin
      req(3'h0, a, 8'h00, 1'b0);
      wt(1'b1, 20);
      chk(got, e);
    end
  endtask
  task stg(input [16:0] a, input [7:0] d, input [7:0] e);
    begin
      req(3'h1, a, d, 1'b0);
      wt(1'b1, 20);
      chk(got, e);
    end
  endtask
  task cmd(input [2:0] op, input p);
    begin
      req(op, 17'h00000, 8'h00, p);
      wt(1'b0, 20000);
    end
  endtask
  // ---------------------------
  // scenarios
  // ---------------------------
  task t_ignored;
    begin
      stg(17'h00412, 8'hC3, 8'h00);
      cmd(3'h2, 1'b0);
      rd(17'h00412, 8'hFF);
    end
  endtask
  task t_page;
    begin
      stg(17'h12390, 8'h5A, 8'h00);
      stg(17'h12380, 8'h21, 8'h00);
      stg(17'h123FE, 8'h96, 8'h00);
      stg(17'h00480, 8'h11, 8'h01);
      cmd(3'h2, 1'b1);
      chk({7'h00, u_dev.prot_q}, 8'h01);
      rd(17'h12390, 8'h5A);
      rd(17'h12380, 8'h21);
      rd(17'h123FE, 8'h96);
      rd(17'h123FF, 8'hFF);
    end
  endtask
  task t_unprot;
    begin
      cmd(3'h3, 1'b0);
      chk({7'h00, u_dev.prot_q}, 8'h00);
      stg(17'h00412, 8'h77, 8'h00);
      cmd(3'h2, 1'b0);
      rd(17'h00412, 8'h77);
    end
  endtask
  task t_ident;
    begin
      cmd(3'h5, 1'b0);
      rd(17'h00000, 8'h3C);
      rd(17'h00001, 8'h5A);
      cmd(3'h6, 1'b0);
      rd(17'h00000, 8'hFF);
    end
  endtask
  // the full erase wait is far too long, so a reset cuts it short
  task t_erase;
    begin
      req(3'h4, 17'h00000, 8'h00, 1'b0);
      n = 0;
      while (u_dev.erase_cnt == 0) begin
        n = n + 1;
        if (n > 200)
          tmo;
        @(posedge clock);
      end
      resetn <= 1'b0;
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      rd(17'h12390, 8'hFF);
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    t_ignored;
    t_page;
    t_unprot;
    t_ident;
    t_erase;
    end_sim;
  end
endmodule // pfc_host_tb
